// [rtl/evc_cfg_pkg.sv]
// constants and register layouts for the event counter edge and clock configuration block
// assumes a 32-bit apb slave with word-aligned registers
package evc_cfg_pkg;

    localparam logic [11:0] OFF_INPUT_EDGE_SELECT      = 12'h000;
    localparam logic [11:0] OFF_COUNTER_CLOCK_CONTROL  = 12'h004;
    localparam logic [11:0] OFF_EVENT_STATUS           = 12'h008;
    localparam logic [11:0] OFF_EVENT_MASK             = 12'h00c;

    localparam logic [7:0] RST_INPUT_EDGE_SELECT     = 8'h00;
    localparam logic [7:0] RST_COUNTER_CLOCK_CONTROL = 8'h00;
    localparam logic [2:0] RST_EVENT_STATUS          = 3'h0;
    localparam logic [2:0] RST_EVENT_MASK            = 3'h0;

    // status and mask bit positions
    localparam int STS_GATE_EDGE = 0;
    localparam int STS_HIGH_EDGE = 1;
    localparam int STS_LOW_EDGE  = 2;
    localparam int STS_WIDTH     = 3;

    // prescaler taps: index i is system clock divided by 2**(i+1)
    localparam int PRESCALE_TAPS = 6;

    typedef enum logic [1:0] {
        EDGE_FALLING = 2'h0,
        EDGE_RISING  = 2'h1,
        EDGE_BOTH    = 2'h2,
        EDGE_NONE    = 2'h3
    } edge_mode_t;

    typedef enum logic [1:0] {
        CLK_PIN  = 2'h0,
        CLK_DIV2 = 2'h1,
        CLK_DIV4 = 2'h2,
        CLK_DIV8 = 2'h3
    } count_clock_t;

    typedef struct packed {
        edge_mode_t high_edge;
        edge_mode_t low_edge;
        edge_mode_t gate_edge;
        logic       gate_pwm_enable;
        logic       reserved0;
    } input_edge_select_t;

    typedef struct packed {
        count_clock_t high_clock;
        count_clock_t low_clock;
        logic [2:0]   pwm_clock;
        logic         reserved0;
    } counter_clock_control_t;

    typedef struct packed {
        logic       high_count_tick;
        logic       low_count_tick;
        logic       pwm_clock_tick;
        logic       gate_pwm_run;
    } count_strobes_t;

endpackage

// [rtl/evc_prescaler.sv]
// free-running system clock prescaler giving one-cycle enable taps
// assumes a single clock domain; taps are /2 up to /2**taps
`timescale 1ns/1ps
module evc_prescaler #(
    parameter int TAPS = 6
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    output logic [TAPS-1:0]      div_tick
);

    logic [TAPS-1:0] count_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + {{(TAPS-1){1'b0}}, 1'b1};
        end
    end

    // tap i fires once every 2**(i+1) cycles
    // running and keeps the part-select bounds constant
    always_comb begin
        logic all_ones;
        all_ones = 1'b1;
        for (int i = 0; i < TAPS; i++) begin
            all_ones    = all_ones & count_q[i];
            div_tick[i] = all_ones;
        end
    end

endmodule

// [rtl/evc_edge_clock_cfg.sv]
// edge select and counter clock control for the async event counter, apb slave
// assumes pins are asynchronous; gate_pwm_output comes from pwm logic on pclk
// Function
// R01 - high input edge: fall, rise, both
// R02 - low input edge: fall, rise, both
// R03 - gate pin edge: fall, rise, both
// R04 - software never writes edge code 11
// R05 - pwm enable 0: pwm halted, pin gates
// R06 - pwm enable 1: pwm runs, pin deselected
// R07 - software keeps reserved bit 0 at 0
// R08 - high clock: pin, /2, /4, /8
// R09 - low clock: pin, /2, /4
// R10 - low clock code 11 gives /8
// R11 - pwm clock /2 to /64, middle ignored
// R12 - counting passes only while gate high
// R13 - software halts pwm before reprogramming it
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module evc_edge_clock_cfg #(
    parameter int ADDR_W = 12
) (
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ADDR_W-1:0]               paddr,
    input  wire logic [31:0]                     pwdata,
    output logic [31:0]                          prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            high_event_input_pin,
    input  wire logic                            low_event_input_pin,
    input  wire logic                            event_gate_interrupt_pin,
    input  wire logic                            gate_pwm_output,
    output evc_cfg_pkg::count_strobes_t          strobes,
    output logic                                 irq
);

    evc_cfg_pkg::input_edge_select_t     edge_sel_q;
    evc_cfg_pkg::counter_clock_control_t clk_ctl_q;
    logic [evc_cfg_pkg::STS_WIDTH-1:0]   status_q;
    logic [evc_cfg_pkg::STS_WIDTH-1:0]   mask_q;
    logic [evc_cfg_pkg::STS_WIDTH-1:0]   status_seen_q;
    logic [evc_cfg_pkg::STS_WIDTH-1:0]   status_set;
    logic [31:0]                         prdata_q;
    logic                                pslverr_q;
    logic [2:0]                          sync1_q;
    logic [2:0]                          sync2_q;
    logic [2:0]                          prev_q;
    logic [evc_cfg_pkg::PRESCALE_TAPS-1:0] div_tick;
    logic                                setup_phase;
    logic                                access_phase;
    logic                                addr_hit;
    logic                                high_hit;
    logic                                low_hit;
    logic                                gate_pin_hit;
    logic                                gate_pwm_prev_q;
    logic                                gate_hit;
    logic                                gate_open;
    logic                                high_src;
    logic                                low_src;
    logic                                pwm_src;
    evc_cfg_pkg::count_strobes_t         strobes_q;

    function automatic logic edge_hit(input evc_cfg_pkg::edge_mode_t mode, input logic prev, input logic cur);
        case (mode)
            evc_cfg_pkg::EDGE_FALLING: edge_hit = prev & ~cur;
            evc_cfg_pkg::EDGE_RISING:  edge_hit = ~prev & cur;
            evc_cfg_pkg::EDGE_BOTH:    edge_hit = prev ^ cur;
            default:                   edge_hit = 1'b0;
        endcase
    endfunction

    function automatic logic clock_pick(input evc_cfg_pkg::count_clock_t sel, input logic pin_hit,
                                        input logic [evc_cfg_pkg::PRESCALE_TAPS-1:0] taps);
        case (sel)
            evc_cfg_pkg::CLK_PIN:  clock_pick = pin_hit;
            evc_cfg_pkg::CLK_DIV2: clock_pick = taps[0];
            evc_cfg_pkg::CLK_DIV4: clock_pick = taps[1];
            evc_cfg_pkg::CLK_DIV8: clock_pick = taps[2];
            default:               clock_pick = 1'b0;
        endcase
    endfunction

    evc_prescaler #(
        .TAPS (evc_cfg_pkg::PRESCALE_TAPS)
    ) u_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .div_tick (div_tick)
    );

    // pins: {gate, low, high}; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q  <= 3'h0;
        end else begin
            sync1_q <= {event_gate_interrupt_pin, low_event_input_pin, high_event_input_pin};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_pwm_prev_q <= 1'b0;
        end else begin
            gate_pwm_prev_q <= gate_pwm_output;
        end
    end

    always_comb begin
        // R01 high edge decode
        high_hit     = edge_hit(edge_sel_q.high_edge, prev_q[0], sync2_q[0]);
        // R02 low edge decode
        low_hit      = edge_hit(edge_sel_q.low_edge, prev_q[1], sync2_q[1]);
        // R03 gate pin edge decode
        gate_pin_hit = edge_hit(edge_sel_q.gate_edge, prev_q[2], sync2_q[2]);
        // R05 R06 pwm output replaces the pin as gate source
        gate_hit     = edge_sel_q.gate_pwm_enable ?
                       edge_hit(edge_sel_q.gate_edge, gate_pwm_prev_q, gate_pwm_output) : gate_pin_hit;
        gate_open    = edge_sel_q.gate_pwm_enable ? gate_pwm_output : sync2_q[2];
        // R08 high clock source
        high_src     = clock_pick(clk_ctl_q.high_clock, high_hit, div_tick);
        // R09 R10 low clock source, code 11 taken as /8
        low_src      = clock_pick(clk_ctl_q.low_clock, low_hit, div_tick);
        // R11 pwm tap, middle bit ignored above /16
        case (clk_ctl_q.pwm_clock)
            3'h0:    pwm_src = div_tick[0];
            3'h1:    pwm_src = div_tick[1];
            3'h2:    pwm_src = div_tick[2];
            3'h3:    pwm_src = div_tick[3];
            3'h4,
            3'h6:    pwm_src = div_tick[4];
            default: pwm_src = div_tick[5];
        endcase
    end

    // strobes registered so the counters see clean one-cycle enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobes_q <= '0;
        end else begin
            // R12 counting gated by pin or pwm level
            strobes_q.high_count_tick <= high_src & gate_open;
            strobes_q.low_count_tick  <= low_src & gate_open;
            // R05 pwm clock halted while disabled
            strobes_q.pwm_clock_tick  <= pwm_src & edge_sel_q.gate_pwm_enable;
            // R06 pwm run level
            strobes_q.gate_pwm_run    <= edge_sel_q.gate_pwm_enable;
        end
    end

    assign strobes = strobes_q;

    // apb: zero wait states, read data captured in setup
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign addr_hit     = (paddr == evc_cfg_pkg::OFF_INPUT_EDGE_SELECT[ADDR_W-1:0]) |
                          (paddr == evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL[ADDR_W-1:0]) |
                          (paddr == evc_cfg_pkg::OFF_EVENT_STATUS[ADDR_W-1:0]) |
                          (paddr == evc_cfg_pkg::OFF_EVENT_MASK[ADDR_W-1:0]);
    assign pready       = 1'b1;
    assign prdata       = prdata_q;
    assign pslverr      = pslverr_q & access_phase;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q      <= 32'h0000_0000;
            pslverr_q     <= 1'b0;
            status_seen_q <= '0;
        end else if (setup_phase) begin
            pslverr_q     <= ~addr_hit;
            status_seen_q <= '0;
            prdata_q      <= 32'h0000_0000;
            if (!pwrite && paddr == evc_cfg_pkg::OFF_EVENT_STATUS[ADDR_W-1:0]) begin
                status_seen_q <= status_q;
            end
            if (!pwrite) begin
                case (paddr)
                    evc_cfg_pkg::OFF_INPUT_EDGE_SELECT[ADDR_W-1:0]:     prdata_q[7:0] <= edge_sel_q;
                    evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL[ADDR_W-1:0]: prdata_q[7:0] <= clk_ctl_q;
                    evc_cfg_pkg::OFF_EVENT_STATUS[ADDR_W-1:0]:          prdata_q[2:0] <= status_q;
                    evc_cfg_pkg::OFF_EVENT_MASK[ADDR_W-1:0]:            prdata_q[2:0] <= mask_q;
                    default:                                            prdata_q      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // reserved bit 0 stays writable; software is expected to keep it 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_q <= evc_cfg_pkg::RST_INPUT_EDGE_SELECT;
            clk_ctl_q  <= evc_cfg_pkg::RST_COUNTER_CLOCK_CONTROL;
            mask_q     <= evc_cfg_pkg::RST_EVENT_MASK;
        end else if (access_phase && pwrite) begin
            case (paddr)
                evc_cfg_pkg::OFF_INPUT_EDGE_SELECT[ADDR_W-1:0]:     edge_sel_q <= pwdata[7:0];
                evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL[ADDR_W-1:0]: clk_ctl_q  <= pwdata[7:0];
                evc_cfg_pkg::OFF_EVENT_MASK[ADDR_W-1:0]:            mask_q     <= pwdata[2:0];
                default:                                            mask_q     <= mask_q;
            endcase
        end
    end

    assign status_set = {low_hit, high_hit, gate_hit};

    // only bits that were returned are cleared; a new set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= evc_cfg_pkg::RST_EVENT_STATUS;
        end else if (access_phase && !pwrite) begin
            status_q <= (status_q & ~status_seen_q) | status_set;
        end else begin
            status_q <= status_q | status_set;
        end
    end

    assign irq = |(status_q & mask_q);

    high_falling_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (edge_sel_q.high_edge == evc_cfg_pkg::EDGE_FALLING && prev_q[0] && !sync2_q[0]) |-> high_hit)
        else $error("high falling edge not sensed");

    low_rising_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        (edge_sel_q.low_edge == evc_cfg_pkg::EDGE_RISING) |-> (low_hit == (!prev_q[1] && sync2_q[1])))
        else $error("low rising edge decode wrong");

    gate_both_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (edge_sel_q.gate_edge == evc_cfg_pkg::EDGE_BOTH && !edge_sel_q.gate_pwm_enable &&
         prev_q[2] != sync2_q[2]) |=> status_q[evc_cfg_pkg::STS_GATE_EDGE])
        else $error("gate pin edge lost");

    pwm_halted_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        !edge_sel_q.gate_pwm_enable |=> !strobes_q.pwm_clock_tick)
        else $error("pwm clock ran while halted");

    pin_deselect_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (edge_sel_q.gate_pwm_enable && !gate_pwm_output && high_src) |=> !strobes_q.high_count_tick)
        else $error("pin gated counting while pwm selected");

    high_div8_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        (clk_ctl_q.high_clock == evc_cfg_pkg::CLK_DIV8 && gate_open && $stable(clk_ctl_q))
        |-> (high_src == div_tick[2]))
        else $error("high clock not divided by 8");

    low_div4_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
        (clk_ctl_q.low_clock == evc_cfg_pkg::CLK_DIV4 && div_tick[1] && gate_open) |=> strobes_q.low_count_tick)
        else $error("low divide by 4 tick missing");

    low_div8_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (clk_ctl_q.low_clock == evc_cfg_pkg::CLK_DIV8 && !div_tick[2]) |-> !low_src)
        else $error("low code 11 not divide by 8");

    pwm_div32_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (clk_ctl_q.pwm_clock[2] && !clk_ctl_q.pwm_clock[0]) |-> (pwm_src == div_tick[4]))
        else $error("pwm 1x0 not divide by 32");

    gate_closed_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        !gate_open |=> (!strobes_q.high_count_tick && !strobes_q.low_count_tick))
        else $error("count passed with gate low");

    high_rising_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (edge_sel_q.high_edge == evc_cfg_pkg::EDGE_RISING) |-> (high_hit == (!prev_q[0] && sync2_q[0])))
        else $error("high rising edge decode wrong");

    high_both_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        (edge_sel_q.high_edge == evc_cfg_pkg::EDGE_BOTH) |-> (high_hit == (prev_q[0] != sync2_q[0])))
        else $error("high both edge decode wrong");

    low_falling_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        (edge_sel_q.low_edge == evc_cfg_pkg::EDGE_FALLING) |-> (low_hit == (prev_q[1] && !sync2_q[1])))
        else $error("low falling edge decode wrong");

    gate_rising_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (edge_sel_q.gate_edge == evc_cfg_pkg::EDGE_RISING && !edge_sel_q.gate_pwm_enable)
        |-> (gate_hit == (!prev_q[2] && sync2_q[2])))
        else $error("gate pin rising edge decode wrong");

    pin_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
        (!edge_sel_q.gate_pwm_enable && sync2_q[2] && low_src) |=> strobes_q.low_count_tick)
        else $error("pin did not open the gate");

    pwm_run_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        edge_sel_q.gate_pwm_enable |=> strobes_q.gate_pwm_run)
        else $error("pwm not running while enabled");

    pwm_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (edge_sel_q.gate_pwm_enable && gate_pwm_output && high_src) |=> strobes_q.high_count_tick)
        else $error("pwm output did not open the gate");

    high_pin_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        (clk_ctl_q.high_clock == evc_cfg_pkg::CLK_PIN && gate_open)
        |=> (strobes_q.high_count_tick == $past(high_hit)))
        else $error("high pin edge not passed as tick");

    low_div2_a: assert property (@(posedge pclk) disable iff (!presetn) // R09
        (clk_ctl_q.low_clock == evc_cfg_pkg::CLK_DIV2 && div_tick[0] && gate_open) |=> strobes_q.low_count_tick)
        else $error("low divide by 2 tick missing");

    pwm_div64_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (clk_ctl_q.pwm_clock[2] && clk_ctl_q.pwm_clock[0]) |-> (pwm_src == div_tick[5]))
        else $error("pwm 1x1 not divide by 64");

    gate_open_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (gate_open && high_src) |=> strobes_q.high_count_tick)
        else $error("count blocked with gate open");

endmodule

// [tb/evc_event_source.sv]
// partner model: the external event pins and the pwm waveform beside the block
// assumes callers time every change from the rising edge of pclk
`timescale 1ns/1ps
module evc_event_source (
    input  wire logic pclk,
    output logic      high_pin,
    output logic      low_pin,
    output logic      gate_pin,
    output logic      pwm_out
);
    logic [3:0] lines_q = 4'h0;

    assign {pwm_out, gate_pin, low_pin, high_pin} = lines_q;

    // each level held 8 cycles, well above the two-cycle minimum width
    task automatic set_line(input int idx, input logic val);
        @(posedge pclk);
        lines_q[idx] <= val;
        repeat (8) @(posedge pclk);
    endtask
endmodule

// [tb/test_evc_edge_clock_cfg.sv]
// self-checking bench for the edge select and counter clock block
// assumes a zero-wait apb slave and the partner model for pins and pwm
`timescale 1ns/1ps
module test_evc_edge_clock_cfg;
    typedef struct {logic rd; logic [31:0] data; logic err;} note_t;
    logic                          pclk    = 1'b0;
    logic                          presetn = 1'b0;
    logic                          psel    = 1'b0;
    logic                          penable = 1'b0;
    logic                          pwrite  = 1'b0;
    logic [11:0]                   paddr   = 12'h000;
    logic [31:0]                   pwdata  = 32'h0;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          hpin, lpin, gpin, pwm;
    evc_cfg_pkg::count_strobes_t   strobes;
    logic                          irq;
    note_t                         notes[$];
    int                            failures, cmp_count, hi_n, lo_n, pw_n;
    logic [31:0]                   seed = 32'h37937d22;

    always #5 pclk = ~pclk;

    evc_event_source src (.pclk(pclk), .high_pin(hpin), .low_pin(lpin), .gate_pin(gpin), .pwm_out(pwm));

    evc_edge_clock_cfg DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .high_event_input_pin(hpin), .low_event_input_pin(lpin), .event_gate_interrupt_pin(gpin),
        .gate_pwm_output(pwm), .strobes(strobes), .irq(irq));

    task automatic complete_run();
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // apb master: holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       input logic [31:0] exp, input logic err, input logic chk);
        int n;
        notes.push_back('{!wr && chk, exp, err});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            complete_run();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [7:0] v);
        apb(1'b1, addr, {24'h0, v}, 32'h0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] addr, input logic [7:0] v, input logic chk);
        apb(1'b0, addr, 32'h0, {24'h0, v}, 1'b0, chk);
    endtask

    task automatic window(input int cycles, output int hi, output int lo, output int pw);
        int h0, l0, p0;
        // the first strobe after a write still reflects the old setting
        repeat (2) @(negedge pclk);
        h0 = hi_n;
        l0 = lo_n;
        p0 = pw_n;
        repeat (cycles) @(negedge pclk);
        hi = hi_n - h0;
        lo = lo_n - l0;
        pw = pw_n - p0;
    endtask

    // monitor: apb answers against the oldest note, tick counting
    always @(posedge pclk) begin
        note_t n;
        if (psel && penable && pready && notes.size() > 0) begin
            n = notes.pop_front();
            check("pslverr", {31'h0, n.err}, {31'h0, pslverr});
            if (n.rd)
                check("prdata", n.data, prdata);
        end
        hi_n += int'(strobes.high_count_tick);
        lo_n += int'(strobes.low_count_tick);
        pw_n += int'(strobes.pwm_clock_tick);
    end

    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        complete_run();
    end

    initial begin
        int hi, lo, pw;
        logic [7:0] v;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, evc_cfg_pkg::RST_INPUT_EDGE_SELECT, 1'b1);
        rd(evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL, evc_cfg_pkg::RST_COUNTER_CLOCK_CONTROL, 1'b1);
        apb(1'b1, 12'h010, 32'hff, 32'h0, 1'b1, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1, 1'b1);
        repeat (4) begin
            seed = next_rand(seed);
            v = seed[7:0];
            // never code 11, bit 0 kept clear
            for (int i = 2; i < 8; i += 2)
                if (v[i+:2] == 2'b11) v[i] = 1'b0;
            v[0] = 1'b0;
            wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, v);
            rd(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, v, 1'b1);
            v = {seed[15:9], 1'b0};
            wr(evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL, v);
            rd(evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL, v, 1'b1);
        end
        wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, 8'h00);
        src.set_line(2, 1'b1);
        for (int c = 1; c < 4; c++) begin
            wr(evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL, {c[1:0], c[1:0], 4'h0});
            window(64, hi, lo, pw);
            check("high ticks", 64 >> c, hi);
            check("low ticks", 64 >> c, lo);
        end
        // pwm clock rate for every code, with pwm enabled
        wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, 8'h02);
        for (int c = 0; c < 8; c++) begin
            wr(evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL, {4'h0, c[2:0], 1'b0});
            window(128, hi, lo, pw);
            check("pwm ticks", 128 >> (c[2] ? 5 + c[0] : c + 1), pw);
            check("pin ticks idle", 0, hi + lo);
        end
        wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, 8'h00);
        wr(evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL, 8'h50);
        src.set_line(2, 1'b0);
        window(64, hi, lo, pw);
        check("closed gate ticks", 0, hi + lo);
        wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, 8'h02);
        src.set_line(3, 1'b1);
        window(64, hi, lo, pw);
        check("pwm gate ticks", 32, hi);
        check("pwm run", 1, strobes.gate_pwm_run);
        src.set_line(3, 1'b0);
        window(64, hi, lo, pw);
        check("pwm low ticks", 0, hi + lo);
        wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, 8'h00);
        repeat (2) @(negedge pclk);
        check("pwm halt", 0, strobes.gate_pwm_run);
        wr(evc_cfg_pkg::OFF_COUNTER_CLOCK_CONTROL, 8'h00);
        src.set_line(2, 1'b1);
        for (int c = 0; c < 3; c++) begin
            wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, {c[1:0], c[1:0], 4'h0});
            fork
                src.set_line(0, 1'b1);
                src.set_line(1, 1'b1);
                window(12, hi, lo, pw);
            join
            check("rise high", c > 0, hi);
            check("rise low", c > 0, lo);
            fork
                src.set_line(0, 1'b0);
                src.set_line(1, 1'b0);
                window(12, hi, lo, pw);
            join
            check("fall high", c != 1, hi);
            check("fall low", c != 1, lo);
        end
        wr(evc_cfg_pkg::OFF_EVENT_MASK, 8'h01);
        for (int c = 0; c < 3; c++) begin
            wr(evc_cfg_pkg::OFF_INPUT_EDGE_SELECT, {4'h0, c[1:0], 2'b00});
            src.set_line(2, 1'b0);
            rd(evc_cfg_pkg::OFF_EVENT_STATUS, 8'h00, 1'b0);
            src.set_line(2, 1'b1);
            check("irq rise", c > 0, irq);
            rd(evc_cfg_pkg::OFF_EVENT_STATUS, {7'h0, c > 0}, 1'b1);
            @(negedge pclk);
            check("irq cleared", 0, irq);
            src.set_line(2, 1'b0);
            rd(evc_cfg_pkg::OFF_EVENT_STATUS, {7'h0, c != 1}, 1'b1);
        end
        wr(evc_cfg_pkg::OFF_EVENT_MASK, 8'h00);
        src.set_line(2, 1'b1);
        check("irq masked", 0, irq);
        rd(evc_cfg_pkg::OFF_EVENT_STATUS, 8'h01, 1'b1);
        repeat (4) @(posedge pclk);
        complete_run();
    end
endmodule
